// >>> hdl/tpc_pkg.sv
`default_nettype none
package tpc_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  // Count clocks a pending duty write must age before it may load
  localparam logic [1:0] LOAD_AGE = 2'h3;
  // Count clocks from strobe rise to slave transfer
  localparam logic [1:0] XFER_DELAY = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_CARRIER = 2'h1;

  typedef enum logic [2:0] {
    TPC_IDLE = 3'b001,
    TPC_MASK = 3'b010,
    TPC_RUN = 3'b100
  } tpc_state_t;
endpackage
`default_nettype wire

// >>> hdl/tpc_if.sv
`default_nettype none
interface tpc_if;
  logic tick;
  logic strobe_in;
  logic master;
  logic slave;
  modport ctrl (output tick, output strobe_in, output master, input slave);
  modport gate (input tick, input strobe_in, input master, output slave);
endinterface
`default_nettype wire

// >>> hdl/tpc_xfer.sv
`default_nettype none
// Frame strobe resync and master to slave enable transfer
module tpc_xfer (
  input wire logic clk,
  input wire logic rst_n,
  tpc_if.gate link
);
  logic sync_a;
  logic sync_b;
  logic strobe_d;
  logic [1:0] delay;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      strobe_d <= 1'b0;
    end else if (link.tick) begin
      sync_a <= link.strobe_in;
      sync_b <= sync_a;
      strobe_d <= sync_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay <= 2'h0;
      link.slave <= 1'b0;
    end else if (link.tick) begin
      if (sync_b && !strobe_d) begin
        delay <= 2'h1;
      end else if (delay != 2'h0) begin
        if (delay == tpc_pkg::XFER_DELAY) begin
          link.slave <= link.master;
          delay <= 2'h0;
        end else begin
          delay <= delay + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tpc_top.sv
// What this block does
// - Cycle match clears counter, raises irq, output active, compare duty next.
// - Duty match makes output inactive, compares cycle next; no clear, no irq.
// - PWM period is N+1 count clocks, active fraction (M+1)/(N+1).
// - First count clock after enable is masked; output inactive until match.
// - Clearing enable returns irq to default and output to inactive.
// - Duty write latched, loaded at old duty match if three clocks aged; loaded at once if not running.
// - Carrier: low compare sets low width, high compare the high width.
// - Remote/master 00,10 low; 01 high; 11 carrier, from frame edge.
// - Master enable is writable; slave enable gates output, read-only.
// - Frame irq resynced to count clock as internal transfer strobe.
// - Master copied to slave on second count clock after strobe rise.
// - Carrier mode drives the carrier pin, gated by frame cycles.
// - Carrier match: irq, clear, invert carrier, alternate low/high compare.
// - Slave clear while carrier high keeps output high until carrier falls.
// - Carrier period N+M+2 count clocks, high fraction (M+1)/(N+M+2).
`default_nettype none
module tpc_top #(
  parameter int unsigned CARRIER_CAPABLE = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic count_tick,
  input wire logic count_enable,
  input wire logic [1:0] timer_mode_reg,
  input wire logic default_level,
  input wire logic output_enable,
  input wire logic [7:0] cycle_compare,
  input wire logic [7:0] duty_compare,
  input wire logic duty_write,
  input wire logic remote_out_enable,
  input wire logic carrier_enable_master,
  input wire logic frame_timer_irq,
  output logic timer_out_pin,
  output logic timer_match_irq,
  output logic carrier_enable_slave,
  output logic [7:0] counter_value
);
  logic rst_s1;
  logic rst_n;
  tpc_pkg::tpc_state_t state;
  logic phase_duty;
  logic [7:0] duty_active;
  logic [7:0] duty_pending;
  logic pending;
  logic [1:0] age;
  logic carrier_clk;
  logic level_hi;
  logic carrier_mode;
  logic [7:0] cmp_sel;
  logic match;
  logic run;
  tpc_if link ();

  // Async assert, release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Carrier mode only where the channel supports it
  assign carrier_mode = (CARRIER_CAPABLE != 0)
    && (timer_mode_reg == tpc_pkg::MODE_CARRIER);
  assign run = (state == tpc_pkg::TPC_RUN);
  // Cycle or low value first, then the duty or high value
  assign cmp_sel = phase_duty ? duty_active : cycle_compare;
  assign match = run && count_tick && (counter_value == cmp_sel);

  assign link.tick = count_tick;
  assign link.strobe_in = frame_timer_irq;
  assign link.master = carrier_enable_master;

  tpc_xfer u_xfer (
    .clk(clk),
    .rst_n(rst_n),
    .link(link)
  );

  // Enable, one masked tick, then run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= tpc_pkg::TPC_IDLE;
    end else begin
      case (state)
        tpc_pkg::TPC_IDLE: begin
          if (count_enable) begin
            state <= tpc_pkg::TPC_MASK;
          end
        end
        tpc_pkg::TPC_MASK: begin
          if (!count_enable) begin
            state <= tpc_pkg::TPC_IDLE;
          end else if (count_tick) begin
            state <= tpc_pkg::TPC_RUN;
          end
        end
        tpc_pkg::TPC_RUN: begin
          if (!count_enable) begin
            state <= tpc_pkg::TPC_IDLE;
          end
        end
        default: state <= tpc_pkg::TPC_IDLE;
      endcase
    end
  end

  // Clears on cycle match, or on every carrier match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= tpc_pkg::CNT_RESET;
    end else if (!count_enable || !run) begin
      counter_value <= tpc_pkg::CNT_RESET;
    end else if (count_tick) begin
      if (match && (carrier_mode || !phase_duty)) begin
        counter_value <= tpc_pkg::CNT_RESET;
      end else begin
        counter_value <= counter_value + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_duty <= 1'b0;
    end else if (!count_enable || !run) begin
      phase_duty <= 1'b0;
    end else if (match) begin
      phase_duty <= !phase_duty;
    end
  end

  // Irq pulse follows the match by one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_match_irq <= 1'b0;
    end else if (!count_enable) begin
      timer_match_irq <= 1'b0;
    end else begin
      timer_match_irq <= match && (carrier_mode || !phase_duty);
    end
  end

  // Duty write staging; a write while not running loads at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_active <= tpc_pkg::CMP_RESET;
      duty_pending <= tpc_pkg::CMP_RESET;
      pending <= 1'b0;
      age <= 2'h0;
    end else if (duty_write) begin
      duty_pending <= duty_compare;
      pending <= 1'b1;
      age <= 2'h0;
      if (!run) begin
        duty_active <= duty_compare;
        pending <= 1'b0;
      end
    end else if (pending) begin
      if (match && phase_duty && age >= tpc_pkg::LOAD_AGE) begin
        duty_active <= duty_pending;
        pending <= 1'b0;
      end else if (count_tick && age != tpc_pkg::LOAD_AGE) begin
        age <= age + 2'h1;
      end
    end
  end

  // Slave gates carrier rises; a started high width always ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_clk <= 1'b0;
      level_hi <= 1'b0;
    end else if (!count_enable) begin
      carrier_clk <= 1'b0;
      level_hi <= 1'b0;
    end else if (carrier_mode) begin
      if (match) begin
        carrier_clk <= !carrier_clk;
      end
      if (!remote_out_enable) begin
        level_hi <= link.slave;
      end else if (link.slave && match && !carrier_clk) begin
        level_hi <= 1'b1;
      end else if (match && carrier_clk) begin
        level_hi <= 1'b0;
      end
    end else if (match) begin
      level_hi <= !phase_duty;
    end
  end

  // Registered pin and slave copy for read back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_out_pin <= 1'b0;
      carrier_enable_slave <= 1'b0;
    end else begin
      carrier_enable_slave <= link.slave;
      if (!output_enable) begin
        timer_out_pin <= 1'b0;
      end else if (carrier_mode) begin
        timer_out_pin <= level_hi;
      end else begin
        timer_out_pin <= level_hi ^ default_level;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tpc_chk.sv
`default_nettype none
module tpc_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic count_enable,
  input wire logic [1:0] timer_mode_reg,
  input wire logic default_level,
  input wire logic output_enable,
  input wire logic carrier_enable_master,
  input wire logic timer_out_pin,
  input wire logic timer_match_irq,
  input wire logic carrier_enable_slave,
  input wire logic [7:0] counter_value
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_stop;
    !count_enable [*4];
  endsequence
  a_irq_one_cycle: assert property (
    timer_match_irq |=> !timer_match_irq) else $error("irq too long");
  a_irq_cnt_zero: assert property (
    timer_match_irq |-> counter_value == 8'h00) else $error("no clear");
  a_stop_irq: assert property (
    s_stop |-> !timer_match_irq) else $error("irq while stopped");
  a_stop_cnt: assert property (
    s_stop |-> counter_value == 8'h00) else $error("count while stopped");
  a_stop_pin: assert property (
    s_stop |-> !$past(output_enable) || $past(timer_mode_reg) != 2'h2 ||
    timer_out_pin == $past(default_level)) else $error("pin not inactive");
  a_oe_pin: assert property (
    !output_enable [*3] |-> !timer_out_pin) else $error("pin driven");
  a_cnt_step: assert property (
    counter_value != $past(counter_value) |-> counter_value == 8'h00 ||
    counter_value == $past(counter_value) + 8'h01) else $error("bad step");
  a_slave_follow: assert property (
    $changed(carrier_enable_slave) |-> carrier_enable_slave ==
    $past(carrier_enable_master, 2)) else $error("slave not master");
endmodule
bind tpc_top tpc_chk u_chk (.*);
`default_nettype wire

// >>> dv/tpc_frame_model.sv
`default_nettype none
module tpc_frame_model (
  input wire logic clk,
  input wire logic fire,
  output logic frame_timer_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial frame_timer_irq = 1'b0;
  // Frame event held over two count clocks
  always @(posedge fire) begin
    @(negedge clk);
    frame_timer_irq = 1'b1;
    repeat (8) @(negedge clk);
    frame_timer_irq = 1'b0;
  end
endmodule
`default_nettype wire

// >>> dv/timer_pwm_and_ir_carrier_tb_top.sv
`default_nettype none
module timer_pwm_and_ir_carrier_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, arst_n = 0, tick = 0, en = 0, dl = 0, oe = 0, dw = 0;
  logic rem = 0, mst = 0, fire = 0, irq_f, pin, irq, slv;
  logic [1:0] mode = 0, div = 0;
  logic [7:0] cyc = 0, duty = 0, cnt;
  int failures = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    div <= div + 2'h1;
    tick <= div == 2'h3;
  end
  tpc_top u_dut (.clk(clk), .arst_n(arst_n), .count_tick(tick),
    .count_enable(en), .timer_mode_reg(mode), .default_level(dl),
    .output_enable(oe), .cycle_compare(cyc), .duty_compare(duty),
    .duty_write(dw), .remote_out_enable(rem),
    .carrier_enable_master(mst), .frame_timer_irq(irq_f),
    .timer_out_pin(pin), .timer_match_irq(irq),
    .carrier_enable_slave(slv), .counter_value(cnt));
  tpc_frame_model u_frame (.clk(clk), .fire(fire), .frame_timer_irq(irq_f));
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic wr;
    dw = 1;
    @(negedge clk);
    dw = 0;
  endtask
  // Pin rise to next rise: period and high count in clocks
  task automatic span(output int per, hi);
    int i;
    per = 0;
    hi = 0;
    for (i = 0; i < 3000 && pin !== 1'b0; i++) @(negedge clk);
    for (i = 0; i < 3000 && pin !== 1'b1; i++) @(negedge clk);
    do begin
      hi += int'(pin === 1'b1);
      @(negedge clk);
      per++;
    end while (per < 3000 && !(pin === 1'b1 && hi < per));
  endtask
  task automatic frame;
    int i;
    fire = 1;
    @(negedge clk);
    fire = 0;
    for (i = 0; i < 200 && slv !== mst; i++) @(negedge clk);
    repeat (8) @(negedge clk);
  endtask
  task automatic t_pwm;
    int p, h, i;
    mode = 2'h2;
    oe = 1;
    cyc = 8'h05;
    duty = 8'h02;
    wr;
    en = 1;
    repeat (12) @(negedge clk);
    chk("pin masked", 0, pin);
    span(p, h);
    chk("pwm period", 24, 16'(p));
    chk("pwm high", 12, 16'(h));
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
    chk("irq", 1, irq);
    chk("cnt at irq", 0, cnt);
    while (pin !== 1'b0) @(negedge clk);
    duty = 8'h03;
    wr;
    span(p, h);
    span(p, h);
    chk("new duty high", 16, 16'(h));
    en = 0;
    repeat (4) @(negedge clk);
    chk("pin off", 0, pin);
    chk("count zero", 0, cnt);
    dl = 1;
    repeat (3) @(negedge clk);
    chk("pin idle high", 1, pin);
    dl = 0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_carrier;
    int p, h;
    mode = 2'h1;
    cyc = 8'h02;
    duty = 8'h04;
    wr;
    rem = 1;
    mst = 1;
    en = 1;
    frame;
    chk("slave set", 1, slv);
    span(p, h);
    chk("carrier period", 32, 16'(p));
    chk("carrier high", 20, 16'(h));
    rem = 0;
    frame;
    repeat (40) @(negedge clk);
    chk("level high", 1, pin);
    rem = 1;
    mst = 0;
    frame;
    repeat (40) @(negedge clk);
    chk("carrier off", 0, pin);
    en = 0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1;
    repeat (3) @(negedge clk);
    t_pwm;
    t_carrier;
    tally_and_finish;
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
